// File: common/tail_pkg.sv
// Constants of the thermal alert and interrupt logic
package tail_pkg;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h01;
   localparam logic [7:0] ADDR_STAT1 = 8'h02;
   localparam logic [7:0] ADDR_STAT2 = 8'h03;
   localparam logic [7:0] ADDR_CTRL4 = 8'h04;
   localparam logic [7:0] ADDR_DEVID = 8'h3D;
   localparam logic [7:0] ADDR_VENID = 8'h3E;
   localparam logic [7:0] ADDR_CTRL3 = 8'h3F;

   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [7:0] RST_CTRL1 = 8'hD4;
   localparam logic [7:0] RST_CTRL2 = 8'h3D;
   localparam logic [7:0] RST_CTRL3 = 8'h82;
   localparam logic [7:0] RST_CTRL4 = 8'h08;
   localparam logic [7:0] RST_STAT = 8'h00;
   localparam logic [7:0] RD_RESERVED = 8'h00;
   localparam logic [7:0] CTRL4_RW_MASK = 8'hF8;
   localparam logic [7:0] STAT2_RW_MASK = 8'hF8;

   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int C1_THERM_IE = 7;
   localparam int C1_FAN_IE = 2;
   localparam int C1_GLOBAL_IE = 1;
   localparam int C2_SOFT_RST = 7;
   localparam int C2_PASSIVE_IE = 6;
   localparam int C2_REMOTE_IE = 5;
   localparam int C2_LOCAL_IE = 4;
   localparam int C2_FAIL_IE = 3;
   localparam int C4_IND_EN = 4;

   // ----------------------------------------
   // Status field positions
   // ----------------------------------------
   localparam int S1_LOCAL_LOW = 7;
   localparam int S1_LOCAL_HIGH = 6;
   localparam int S1_REMOTE_FAIL = 5;
   localparam int S1_REMOTE_THERM = 4;
   localparam int S1_REMOTE_LOW = 3;
   localparam int S1_REMOTE_HIGH = 2;
   localparam int S1_FAN_SLOW = 1;
   localparam int S1_FAN_FAST = 0;
   localparam int S2_THERM_IN = 7;
   localparam int S2_LOCAL_THERM = 6;
   localparam int S2_LOCAL_PASSIVE = 5;
   localparam int S2_LOCAL_CRIT = 4;
   localparam int S2_REMOTE_CRIT = 3;

   // ----------------------------------------
   // Critical hysteresis in degrees C
   // ----------------------------------------
   localparam logic signed [9:0] CRIT_HYST_DEG = 10'sh005;

endpackage : tail_pkg

// File: design/tail_core.sv
// Alert and interrupt logic with its register file
// Summary of operation
// - Two active-low interrupt outputs: critical indicator and bus alert line.
// - Critical indicator is open-drain, signalling over-critical and sensor failure.
// - Indicator disabled floats; enabled it follows critical conditions and failure flag.
// - Each channel at or above its critical limit sets its own critical flag.
// - Reading status registers clears the over-critical flags.
// - Cleared critical flag re-arms only after temperature falls 5 C below limit.
// - Indicator pulled low while temperature at or above critical limit.
// - Indicator stays low until temperature falls 5 C below the limit.
// - Sensor short or open sets failure flag and forces indicator low.
// - Failure flag and low indicator hold until power-on or software reset.
// - Failure flag with its enable also asserts the bus alert line.
// - Out-of-limit events set status flags; alert only when enabled.
// - A generated interrupt pulls the open-drain alert line low.
// - Limit status bits stay set until condition ends and status read.
// - Alert stays low while out of limits and until status is read.
// - Clearing an enable masks only the alert, status still sets.
// - Per-source enables in control registers plus a global enable gate alert.
// - Every register is eight bits wide.
// - Reserved locations read zero and ignore writes.
`timescale 1ns/10ps
module tail_core #(
   parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] VENDOR_ID = 8'hA5 // Arbitrary value
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Local channel events
   input wire logic local_low_cond,
   input wire logic local_high_cond,
   input wire logic local_therm_cond,
   input wire logic local_passive_cond,
   input wire logic [7:0] local_temp,
   input wire logic [7:0] local_crit_limit,
   // Remote channel events
   input wire logic remote_low_cond,
   input wire logic remote_high_cond,
   input wire logic remote_therm_cond,
   input wire logic remote_fail_cond,
   input wire logic [7:0] remote_temp,
   input wire logic [7:0] remote_crit_limit,
   // Fan and external events
   input wire logic fan_slow_cond,
   input wire logic fan_fast_cond,
   input wire logic therm_in_cond,
   // Critical indicator pin
   output logic critical_indicator_out,
   output logic critical_indicator_oe_n,
   // Bus alert pin
   output logic smbus_alert_out,
   output logic smbus_alert_oe_n,
   // Control values for the other blocks
   output logic [7:0] control_primary,
   output logic [7:0] control_secondary,
   output logic [7:0] control_tertiary,
   output logic [7:0] control_quaternary
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] ctrl3;
      logic [7:0] ctrl4;
      logic [7:0] stat1;
      logic [7:0] stat2;
      logic l_armed;
      logic r_armed;
      logic l_crit_act;
      logic r_crit_act;
      logic ind_oe_n;
      logic alert_oe_n;
      logic [7:0] rdata;
   } tail_state_s;

   localparam tail_state_s TAIL_RESET = '{
      ctrl1: tail_pkg::RST_CTRL1,
      ctrl2: tail_pkg::RST_CTRL2,
      ctrl3: tail_pkg::RST_CTRL3,
      ctrl4: tail_pkg::RST_CTRL4,
      stat1: tail_pkg::RST_STAT,
      stat2: tail_pkg::RST_STAT,
      l_armed: 1'b1,
      r_armed: 1'b1,
      l_crit_act: 1'b0,
      r_crit_act: 1'b0,
      ind_oe_n: 1'b1,
      alert_oe_n: 1'b1,
      rdata: tail_pkg::RD_RESERVED
   };

   tail_state_s state_r;
   tail_state_s state_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic crit_hit(input logic [7:0] temp, input logic [7:0] lim);
      crit_hit = $signed(temp) >= $signed(lim);
   endfunction : crit_hit

   function automatic logic crit_release(input logic [7:0] temp, input logic [7:0] lim);
      logic signed [9:0] t;
      logic signed [9:0] l;
      t = $signed({temp[7], temp[7], temp});
      l = $signed({lim[7], lim[7], lim});
      crit_release = (t + tail_pkg::CRIT_HYST_DEG) <= l;
   endfunction : crit_release

   function automatic logic sticky(input logic cond, input logic flag, input logic rd_clr);
      sticky = cond | (flag & ~rd_clr);
   endfunction : sticky

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic rd_stat1;
   logic rd_stat2;
   logic l_hit;
   logic r_hit;
   logic l_rel;
   logic r_rel;
   logic l_set;
   logic r_set;
   logic soft_rst;
   logic [7:0] mask1;
   logic [7:0] mask2;
   logic [7:0] rd_mux;
   logic rd_stat_any;
   logic [7:0] alert_src1;
   logic [7:0] alert_src2;
   logic alert_req;
   logic ind_req;

   always_comb
   begin
      rd_stat1 = reg_rd && (reg_addr == tail_pkg::ADDR_STAT1);
      rd_stat2 = reg_rd && (reg_addr == tail_pkg::ADDR_STAT2);
      rd_stat_any = rd_stat1 | rd_stat2;
      l_hit = crit_hit(local_temp, local_crit_limit);
      r_hit = crit_hit(remote_temp, remote_crit_limit);
      l_rel = crit_release(local_temp, local_crit_limit);
      r_rel = crit_release(remote_temp, remote_crit_limit);
      l_set = state_r.l_armed & l_hit;
      r_set = state_r.r_armed & r_hit;
      soft_rst = reg_wr && (reg_addr == tail_pkg::ADDR_CTRL2)
                 && reg_wdata[tail_pkg::C2_SOFT_RST];

      // Read data mux, eight bits wide, reserved reads zero
      case (reg_addr)
         tail_pkg::ADDR_CTRL1: rd_mux = state_r.ctrl1;
         tail_pkg::ADDR_CTRL2: rd_mux = state_r.ctrl2;
         tail_pkg::ADDR_STAT1: rd_mux = state_r.stat1;
         tail_pkg::ADDR_STAT2: rd_mux = state_r.stat2;
         tail_pkg::ADDR_CTRL4: rd_mux = state_r.ctrl4;
         tail_pkg::ADDR_DEVID: rd_mux = DEVICE_ID;
         tail_pkg::ADDR_VENID: rd_mux = VENDOR_ID;
         tail_pkg::ADDR_CTRL3: rd_mux = state_r.ctrl3;
         default: rd_mux = tail_pkg::RD_RESERVED;
      endcase
   end

   // ----------------------------------------
   // State update
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      if (reg_rd)
      begin
         state_nxt.rdata = rd_mux;
      end

      // Register writes; unmapped and read-only addresses ignore writes
      if (reg_wr)
      begin
         case (reg_addr)
            tail_pkg::ADDR_CTRL1: state_nxt.ctrl1 = reg_wdata;
            tail_pkg::ADDR_CTRL2: state_nxt.ctrl2 = reg_wdata;
            tail_pkg::ADDR_CTRL3: state_nxt.ctrl3 = reg_wdata;
            tail_pkg::ADDR_CTRL4: state_nxt.ctrl4 = reg_wdata & tail_pkg::CTRL4_RW_MASK;
            default: state_nxt.ctrl1 = state_r.ctrl1;
         endcase
      end

      // ----------------------------------------
      // Sticky limit flags, set wins over read clear
      // ----------------------------------------
      state_nxt.stat1[tail_pkg::S1_LOCAL_LOW] =
         sticky(local_low_cond, state_r.stat1[tail_pkg::S1_LOCAL_LOW], rd_stat1);
      state_nxt.stat1[tail_pkg::S1_LOCAL_HIGH] =
         sticky(local_high_cond, state_r.stat1[tail_pkg::S1_LOCAL_HIGH], rd_stat1);
      state_nxt.stat1[tail_pkg::S1_REMOTE_THERM] =
         sticky(remote_therm_cond, state_r.stat1[tail_pkg::S1_REMOTE_THERM], rd_stat1);
      state_nxt.stat1[tail_pkg::S1_REMOTE_LOW] =
         sticky(remote_low_cond, state_r.stat1[tail_pkg::S1_REMOTE_LOW], rd_stat1);
      state_nxt.stat1[tail_pkg::S1_REMOTE_HIGH] =
         sticky(remote_high_cond, state_r.stat1[tail_pkg::S1_REMOTE_HIGH], rd_stat1);
      state_nxt.stat1[tail_pkg::S1_FAN_SLOW] =
         sticky(fan_slow_cond, state_r.stat1[tail_pkg::S1_FAN_SLOW], rd_stat1);
      state_nxt.stat1[tail_pkg::S1_FAN_FAST] =
         sticky(fan_fast_cond, state_r.stat1[tail_pkg::S1_FAN_FAST], rd_stat1);
      state_nxt.stat2[tail_pkg::S2_THERM_IN] =
         sticky(therm_in_cond, state_r.stat2[tail_pkg::S2_THERM_IN], rd_stat2);
      state_nxt.stat2[tail_pkg::S2_LOCAL_THERM] =
         sticky(local_therm_cond, state_r.stat2[tail_pkg::S2_LOCAL_THERM], rd_stat2);
      state_nxt.stat2[tail_pkg::S2_LOCAL_PASSIVE] =
         sticky(local_passive_cond, state_r.stat2[tail_pkg::S2_LOCAL_PASSIVE], rd_stat2);

      // Sensor failure holds until reset, never cleared by a read
      state_nxt.stat1[tail_pkg::S1_REMOTE_FAIL] =
         state_r.stat1[tail_pkg::S1_REMOTE_FAIL] | remote_fail_cond;

      // ----------------------------------------
      // Critical flags: set once per excursion, cleared by a status read
      // ----------------------------------------
      state_nxt.stat2[tail_pkg::S2_LOCAL_CRIT] =
         l_set | (state_r.stat2[tail_pkg::S2_LOCAL_CRIT] & ~rd_stat_any);
      state_nxt.stat2[tail_pkg::S2_REMOTE_CRIT] =
         r_set | (state_r.stat2[tail_pkg::S2_REMOTE_CRIT] & ~rd_stat_any);
      state_nxt.stat2 = state_nxt.stat2 & tail_pkg::STAT2_RW_MASK;

      // ----------------------------------------
      // Re-arm only after falling through the hysteresis band
      // ----------------------------------------
      if (l_rel)
      begin
         state_nxt.l_armed = 1'b1;
      end
      else if (l_set)
      begin
         state_nxt.l_armed = 1'b0;
      end
      if (r_rel)
      begin
         state_nxt.r_armed = 1'b1;
      end
      else if (r_set)
      begin
         state_nxt.r_armed = 1'b0;
      end

      // ----------------------------------------
      // Critical condition with hysteresis drives the indicator
      // ----------------------------------------
      if (l_hit)
      begin
         state_nxt.l_crit_act = 1'b1;
      end
      else if (l_rel)
      begin
         state_nxt.l_crit_act = 1'b0;
      end
      if (r_hit)
      begin
         state_nxt.r_crit_act = 1'b1;
      end
      else if (r_rel)
      begin
         state_nxt.r_crit_act = 1'b0;
      end

      // Software reset restores every default except read data, failure flag included
      if (soft_rst)
      begin
         state_nxt = TAIL_RESET;
         state_nxt.rdata = state_r.rdata;
      end

      // ----------------------------------------
      // Alert source masks
      // ----------------------------------------
      mask1 = '0;
      mask1[tail_pkg::S1_LOCAL_LOW] = state_nxt.ctrl2[tail_pkg::C2_LOCAL_IE];
      mask1[tail_pkg::S1_LOCAL_HIGH] = state_nxt.ctrl2[tail_pkg::C2_LOCAL_IE];
      mask1[tail_pkg::S1_REMOTE_FAIL] = state_nxt.ctrl2[tail_pkg::C2_FAIL_IE];
      mask1[tail_pkg::S1_REMOTE_THERM] = state_nxt.ctrl1[tail_pkg::C1_THERM_IE];
      mask1[tail_pkg::S1_REMOTE_LOW] = state_nxt.ctrl2[tail_pkg::C2_REMOTE_IE];
      mask1[tail_pkg::S1_REMOTE_HIGH] = state_nxt.ctrl2[tail_pkg::C2_REMOTE_IE];
      mask1[tail_pkg::S1_FAN_SLOW] = state_nxt.ctrl1[tail_pkg::C1_FAN_IE];
      mask1[tail_pkg::S1_FAN_FAST] = state_nxt.ctrl1[tail_pkg::C1_FAN_IE];
      mask2 = '0;
      mask2[tail_pkg::S2_THERM_IN] = state_nxt.ctrl1[tail_pkg::C1_THERM_IE];
      mask2[tail_pkg::S2_LOCAL_THERM] = state_nxt.ctrl1[tail_pkg::C1_THERM_IE];
      mask2[tail_pkg::S2_LOCAL_PASSIVE] = state_nxt.ctrl2[tail_pkg::C2_PASSIVE_IE];
      mask2[tail_pkg::S2_LOCAL_CRIT] = state_nxt.ctrl1[tail_pkg::C1_THERM_IE];
      mask2[tail_pkg::S2_REMOTE_CRIT] = state_nxt.ctrl1[tail_pkg::C1_THERM_IE];

      // Alert pulled low by any enabled flag under the global enable
      alert_src1 = state_nxt.stat1 & mask1;
      alert_src2 = state_nxt.stat2 & mask2;
      alert_req = state_nxt.ctrl1[tail_pkg::C1_GLOBAL_IE]
                  & ((|alert_src1) | (|alert_src2));
      state_nxt.alert_oe_n = ~alert_req;

      // Indicator: OR of both critical conditions and the failure flag
      ind_req = state_nxt.l_crit_act | state_nxt.r_crit_act
                | state_nxt.stat1[tail_pkg::S1_REMOTE_FAIL];
      state_nxt.ind_oe_n = ~(state_nxt.ctrl4[tail_pkg::C4_IND_EN] & ind_req);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= TAIL_RESET;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata = state_r.rdata;
   assign critical_indicator_out = 1'b0;
   assign critical_indicator_oe_n = state_r.ind_oe_n;
   assign smbus_alert_out = 1'b0;
   assign smbus_alert_oe_n = state_r.alert_oe_n;
   assign control_primary = state_r.ctrl1;
   assign control_secondary = state_r.ctrl2;
   assign control_tertiary = state_r.ctrl3;
   assign control_quaternary = state_r.ctrl4;

endmodule : tail_core

// File: tb/tail_props.sv
// Checker of the indicator and alert pins
`timescale 1ns/10ps
module tail_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Remote channel
   input wire logic remote_fail_cond,
   input wire logic [7:0] remote_temp,
   input wire logic [7:0] remote_crit_limit,
   // Pins
   input wire logic critical_indicator_out,
   input wire logic critical_indicator_oe_n,
   input wire logic smbus_alert_out,
   input wire logic smbus_alert_oe_n,
   // Controls
   input wire logic [7:0] control_primary,
   input wire logic [7:0] control_secondary,
   input wire logic [7:0] control_quaternary
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence fail_event_s;
      remote_fail_cond && control_quaternary[4] && !reg_wr;
   endsequence
   sequence no_write_s;
      (!reg_wr) [*4];
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   open_drain_a: assert property (!critical_indicator_out && !smbus_alert_out)
      else $error("open-drain data not low");
   ind_float_a: assert property (!control_quaternary[4] |-> critical_indicator_oe_n)
      else $error("indicator driven while disabled");
   crit_low_a: assert property ($signed(remote_temp) >= $signed(remote_crit_limit)
      && control_quaternary[4] && !reg_wr |=> !critical_indicator_oe_n)
      else $error("indicator not low at critical temperature");
   fail_hold_a: assert property (fail_event_s ##1 no_write_s |-> !critical_indicator_oe_n)
      else $error("indicator released after sensor failure");
   alert_fail_a: assert property (remote_fail_cond && control_primary[1]
      && control_secondary[3] && !reg_wr |=> !smbus_alert_oe_n)
      else $error("alert not raised on sensor failure");
   alert_hold_a: assert property (!smbus_alert_oe_n && !reg_rd && !reg_wr
      |=> !smbus_alert_oe_n)
      else $error("alert released without a read");
   global_off_a: assert property (!control_primary[1] |-> smbus_alert_oe_n)
      else $error("alert low with global enable off");
   reserved_rd_a: assert property (reg_rd && reg_addr inside {[8'h05:8'h3C]}
      |=> reg_rdata == 8'h00)
      else $error("reserved read not zero");
endmodule : tail_props

bind tail_core tail_props tail_props_i (.ref_clk, .reset, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .remote_fail_cond, .remote_temp, .remote_crit_limit, .critical_indicator_out,
   .critical_indicator_oe_n, .smbus_alert_out, .smbus_alert_oe_n, .control_primary,
   .control_secondary, .control_quaternary);

// File: tb/tail_host.sv
// Host model driving the register port
`timescale 1ns/10ps
module tail_host (
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // ----------------------------------------
   // Accesses, entered at a falling edge
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
      @(negedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      v = reg_rdata;
      reg_addr = ~a;
      @(negedge ref_clk);
   endtask : rd
   // Alert service: find the source, then mask the failure source
   task automatic service(output logic [7:0] s);
      logic [7:0] c;
      rd(8'h02, s);
      rd(8'h01, c);
      wr(8'h01, c & 8'hF7);
   endtask : service
endmodule : tail_host

// File: tb/test_thermal_alert_interrupt_logic.sv
// Self-checking bench of the alert and interrupt logic
`timescale 1ns/10ps
module test_thermal_alert_interrupt_logic;
   localparam logic [7:0] RA [9] = '{8'h00, 8'h01, 8'h3F, 8'h04, 8'h02, 8'h03, 8'h3D, 8'h3E, 8'h10};
   localparam logic [7:0] RV [9] = '{8'hD4, 8'h3D, 8'h82, 8'h08, 8'h00, 8'h00, 8'h5A, 8'hA5, 8'h00};
   localparam logic [7:0] SB [10] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h08, 8'h04, 8'h10, 8'h02,
      8'h01, 8'h80};
   localparam logic [9:0] IN_S2 = 10'h20C;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [9:0] cond = 10'h000;
   logic remote_fail_cond = 1'b0;
   logic [7:0] local_temp = 8'h10;
   logic [7:0] remote_temp = 8'h10;
   logic [7:0] lim = 8'h50;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a, ctl1, ctl2, ctl3, ctl4;
   logic reg_wr, reg_rd, ind_oe_n, alert_oe_n;
   int n_errors = 0;
   int cmp_count = 0;

   always #25 ref_clk = ~ref_clk;

   tail_host host_i (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
   tail_core #(.DEVICE_ID(8'h5A), .VENDOR_ID(8'hA5)) tail_core_i (
      .ref_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .local_low_cond(cond[0]), .local_high_cond(cond[1]), .local_therm_cond(cond[2]),
      .local_passive_cond(cond[3]), .local_temp, .local_crit_limit(lim),
      .remote_low_cond(cond[4]), .remote_high_cond(cond[5]), .remote_therm_cond(cond[6]),
      .remote_fail_cond, .remote_temp, .remote_crit_limit(lim),
      .fan_slow_cond(cond[7]), .fan_fast_cond(cond[8]), .therm_in_cond(cond[9]),
      .critical_indicator_out(), .critical_indicator_oe_n(ind_oe_n), .smbus_alert_out(),
      .smbus_alert_oe_n(alert_oe_n), .control_primary(ctl1), .control_secondary(ctl2),
      .control_tertiary(ctl3), .control_quaternary(ctl4));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      cmp_count++;
      if (got !== want)
      begin
         n_errors++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, want);
      end
   endtask : chk
   task automatic chk_pin(input logic got, input logic want);
      cmp_count++;
      if (got !== want)
      begin
         n_errors++;
         $display("unexpected at %0t: pin %b, wanted %b", $time, got, want);
      end
   endtask : chk_pin
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic finish_test;
      $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      cyc(2);
      reset = 1'b0;
      cyc(1);
      for (int i = 0; i < 9; i++)
      begin
         host_i.rd(RA[i], d);
         chk(d, RV[i]);
      end
      chk(ctl1, 8'hD4);
      chk(ctl2, 8'h3D);
      chk(ctl3, 8'h82);
      chk(ctl4, 8'h08);
      host_i.wr(8'h3D, 8'hFF);
      host_i.wr(8'h10, 8'hFF);
      host_i.rd(8'h3D, d);
      chk(d, 8'h5A);
      host_i.rd(8'h10, d);
      chk(d, 8'h00);
      host_i.wr(8'h04, 8'hFF);
      host_i.rd(8'h04, d);
      chk(d, 8'hF8);
      host_i.wr(8'h04, 8'h08);
      remote_temp = lim;
      cyc(1);
      chk_pin(ind_oe_n, 1'b1);
      chk_pin(alert_oe_n, 1'b1);
      host_i.rd(8'h03, d);
      chk(d, 8'h08);
      host_i.rd(8'h03, d);
      chk(d, 8'h00);
      host_i.wr(8'h04, 8'h18);
      chk_pin(ind_oe_n, 1'b0);
      remote_temp = lim - 8'h04;
      cyc(1);
      chk_pin(ind_oe_n, 1'b0);
      remote_temp = lim - 8'h05;
      cyc(1);
      chk_pin(ind_oe_n, 1'b1);
      remote_temp = lim;
      cyc(1);
      host_i.rd(8'h03, d);
      chk(d, 8'h08);
      remote_temp = 8'h10;
      local_temp = lim;
      cyc(1);
      chk_pin(ind_oe_n, 1'b0);
      host_i.rd(8'h03, d);
      chk(d, 8'h10);
      local_temp = 8'h10;
      cyc(1);
      chk_pin(ind_oe_n, 1'b1);
      host_i.wr(8'h00, 8'hD6);
      host_i.wr(8'h01, 8'h7D);
      for (int i = 0; i < 10; i++)
      begin
         a = IN_S2[i] ? 8'h03 : 8'h02;
         cond[i] = 1'b1;
         cyc(1);
         chk_pin(alert_oe_n, 1'b0);
         host_i.rd(a, d);
         host_i.rd(a, d);
         chk(d & SB[i], SB[i]);
         cond[i] = 1'b0;
         cyc(1);
         chk_pin(alert_oe_n, 1'b0);
         host_i.rd(a, d);
         chk_pin(alert_oe_n, 1'b1);
         host_i.rd(a, d);
         chk(d & SB[i], 8'h00);
      end
      host_i.wr(8'h01, 8'h5D);
      cond[5] = 1'b1;
      cyc(1);
      cond[5] = 1'b0;
      cyc(1);
      chk_pin(alert_oe_n, 1'b1);
      host_i.rd(8'h02, d);
      chk(d, 8'h04);
      host_i.rd(8'h02, d);
      chk(d, 8'h00);
      host_i.wr(8'h01, 8'h7D);
      remote_fail_cond = 1'b1;
      cyc(1);
      remote_fail_cond = 1'b0;
      cyc(1);
      chk_pin(ind_oe_n, 1'b0);
      chk_pin(alert_oe_n, 1'b0);
      host_i.service(d);
      chk(d, 8'h20);
      host_i.rd(8'h02, d);
      chk(d, 8'h20);
      chk_pin(alert_oe_n, 1'b1);
      chk_pin(ind_oe_n, 1'b0);
      host_i.wr(8'h01, 8'h80);
      chk_pin(ind_oe_n, 1'b1);
      host_i.rd(8'h01, d);
      chk(d, 8'h3D);
      chk(ctl2, 8'h3D);
      host_i.rd(8'h02, d);
      chk(d, 8'h00);
      finish_test();
   end

   initial
   begin
      #200000;
      n_errors++;
      finish_test();
   end
endmodule : test_thermal_alert_interrupt_logic
